/* src/host_bus_defs.vh */
// Purpose: constants for the host-bus pin control block
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes:   cpu modes are a static two-bit strap
// Operation
// R01: Modes 0/1 master: strobe read/write low
// R02: Modes 0/1 slave: host strobes, device answers
// R03: Unused read/high-select lines read as high
// R04: Modes 2/3 master: direction high means input
// R05: Modes 2/3 slave: direction high means read
// R06: Low select is address bit or strobe
// R07: High select is byte enable or strobe
// R08: Chip select starts access only in slave
// R09: Mode 0 samples wait on rising edge
// R10: Modes 1-3 sample wait on falling edge
// R11: Slave drives wait high to stretch access
// R12: Reset and stop: lines input, wait high
// R13: Reset held at least six clock cycles
// R14: Master only after bus grant input
// R15: Cpu mode is static, selects pin roles
`ifndef HOST_BUS_DEFS_VH
`define HOST_BUS_DEFS_VH
`define CPU_MODE_0      2'h0
`define CPU_MODE_1      2'h1
`define CPU_MODE_2      2'h2
`define CPU_MODE_3      2'h3
`define RESET_MIN_CYC   3'h6
`define BST_IDLE        3'h0
`define BST_ADDR        3'h1
`define BST_SECOND      3'h2
`define BST_WAIT        3'h3
`define BST_THIRD       3'h4
`endif

/* src/wait_sampler.v */
// Purpose: samples the wait line at the chosen edge phase
// Assumes: wait input synchronous to sys_clk
// Notes:   falling-edge sampling is modelled by using the level registered one full state (one clock) earlier
`timescale 1ns/1ps
module wait_sampler (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst,
    // Control
    input  wire       sample_early,
    input  wire       in_wait_phase,
    input  wire       wait_in,
    // Result
    output reg        wait_seen_q
);
    reg late_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            late_q      <= 1'b0;
            wait_seen_q <= 1'b0;
        end else begin
            late_q <= wait_in;
            // Mode 0 looks at the rising edge, others use the level registered one clock earlier
            wait_seen_q <= in_wait_phase &
                           (sample_early ? wait_in : late_q); // R09 R10
        end
    end
endmodule

/* src/host_bus_pin_control.v */
// Purpose: pin-role control for the host bus strobes and wait line
// Assumes: dma core supplies requests; host pins synchronous
// Notes:   address and data lines are handled elsewhere
`timescale 1ns/1ps
`include "host_bus_defs.vh"
module host_bus_pin_control (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst,
    // Static configuration
    input  wire [1:0] cpu_mode,
    input  wire       system_stop,
    // Bus grant
    input  wire       bus_grant_input,
    // Internal dma request side
    input  wire       dma_req,
    input  wire       dma_write,
    input  wire       dma_addr0,
    input  wire       dma_high_byte,
    input  wire       dma_low_byte,
    output reg        dma_done_q,
    // Internal register side
    input  wire       reg_busy,
    output reg        reg_access_q,
    output reg        reg_write_q,
    output reg        reg_low_q,
    output reg        reg_high_q,
    // Host read line
    input  wire       rd_i,
    output reg        rd_o_q,
    output reg        rd_oe_q,
    // Write or direction line
    input  wire       wr_i,
    output reg        wr_o_q,
    output reg        wr_oe_q,
    // Low byte select line
    input  wire       low_byte_select_line_i,
    output reg        lbs_o_q,
    output reg        lbs_oe_q,
    // High byte select line
    input  wire       high_byte_select_line_i,
    output reg        hbs_o_q,
    output reg        hbs_oe_q,
    // Chip select
    input  wire       cs_n,
    // Wait line
    input  wire       wait_i,
    output reg        wait_o_q,
    output reg        wait_oe_q,
    // Status
    output reg        master_q
);
    reg  [2:0] bst_q;
    reg  [2:0] bst_d;
    reg  [1:0] mode_q;
    reg  [2:0] rst_cnt_q;
    reg        op_write_q;
    wire       wait_seen;
    wire       mode01;
    wire       rd_eff;
    wire       hbs_eff;
    wire       slave_ok;
    wire       host_read;
    wire       host_write;
    wire       strobe_on;
    wire       host_strobe;

    assign mode01   = (mode_q == `CPU_MODE_0) | (mode_q == `CPU_MODE_1);
    // Unused lines read high whatever the board does
    assign rd_eff   = mode01 ? rd_i : 1'b1; // R03
    assign hbs_eff  = (mode_q == `CPU_MODE_1) ? 1'b1 :
                      high_byte_select_line_i; // R03
    // Chip select ignored in master, reset and stop
    assign slave_ok = ~master_q & ~system_stop & ~cs_n; // R08
    // Modes 2/3 carry no read strobe; a data strobe qualifies the access
    assign host_strobe = ~low_byte_select_line_i | ~hbs_eff; // R06 R07
    assign host_read  = mode01 ? ~rd_eff : (wr_i & host_strobe);  // R02 R05
    assign host_write = mode01 ? ~wr_i : (~wr_i & host_strobe);   // R02 R05
    assign strobe_on  = (bst_q == `BST_SECOND) | (bst_q == `BST_WAIT);

    wait_sampler u_wait (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .sample_early  (mode_q == `CPU_MODE_0),
        .in_wait_phase (strobe_on & master_q),
        .wait_in       (wait_i),
        .wait_seen_q   (wait_seen)
    );

    // Mode strap sampled on each of the six clocks after reset, then held; changing it live is unsupported
    always @(posedge sys_clk) begin
        if (rst) begin
            mode_q    <= `CPU_MODE_0;
            rst_cnt_q <= 3'h0;
        end else if (rst_cnt_q != `RESET_MIN_CYC) begin
            rst_cnt_q <= rst_cnt_q + 3'h1;
            mode_q    <= cpu_mode; // R15
        end
    end

    // Bus state sequence while mastering
    always @* begin
        bst_d = bst_q;
        case (bst_q)
            `BST_IDLE:
                if (master_q & dma_req)
                    bst_d = `BST_ADDR;
            `BST_ADDR:
                bst_d = `BST_SECOND;
            `BST_SECOND:
                bst_d = `BST_WAIT;
            `BST_WAIT:
                // Stay while wait was seen high
                if (!wait_seen)
                    bst_d = `BST_THIRD; // R09 R10
            `BST_THIRD:
                bst_d = `BST_IDLE;
            default:
                bst_d = `BST_IDLE;
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst | system_stop) begin
            bst_q      <= `BST_IDLE;
            master_q   <= 1'b0;
            op_write_q <= 1'b0;
            dma_done_q <= 1'b0;
        end else begin
            bst_q      <= bst_d;
            dma_done_q <= (bst_q == `BST_THIRD);
            if (bst_q == `BST_IDLE)
                master_q <= bus_grant_input; // R14
            if (bst_q == `BST_IDLE && bst_d == `BST_ADDR)
                op_write_q <= dma_write;
        end
    end

    // Pin drivers
    always @(posedge sys_clk) begin
        if (rst | system_stop) begin
            rd_o_q    <= 1'b1; // R12
            rd_oe_q   <= 1'b0;
            wr_o_q    <= 1'b1;
            wr_oe_q   <= 1'b0;
            lbs_o_q   <= 1'b1;
            lbs_oe_q  <= 1'b0;
            hbs_o_q   <= 1'b1;
            hbs_oe_q  <= 1'b0;
            wait_o_q  <= 1'b1; // R12
            wait_oe_q <= 1'b1;
        end else if (master_q) begin
            rd_oe_q   <= mode01; // R03
            wr_oe_q   <= 1'b1;
            lbs_oe_q  <= 1'b1; // R06
            hbs_oe_q  <= (mode_q != `CPU_MODE_1); // R07
            wait_oe_q <= 1'b0;
            wait_o_q  <= 1'b1;
            if (mode01) begin
                rd_o_q  <= ~(strobe_on & ~op_write_q); // R01
                wr_o_q  <= ~(strobe_on & op_write_q);  // R01
                lbs_o_q <= dma_addr0; // R06
                hbs_o_q <= ~dma_high_byte; // R07
            end else begin
                rd_o_q  <= 1'b1;
                wr_o_q  <= ~op_write_q; // R04
                lbs_o_q <= ~(strobe_on & dma_low_byte);  // R06
                hbs_o_q <= ~(strobe_on & dma_high_byte); // R07
            end
        end else begin
            rd_o_q    <= 1'b1;
            rd_oe_q   <= 1'b0;
            wr_o_q    <= 1'b1;
            wr_oe_q   <= 1'b0;
            lbs_o_q   <= 1'b1;
            lbs_oe_q  <= 1'b0;
            hbs_o_q   <= 1'b1;
            hbs_oe_q  <= 1'b0;
            wait_oe_q <= 1'b1;
            wait_o_q  <= slave_ok & reg_busy; // R11
        end
    end

    // Slave register access decode
    always @(posedge sys_clk) begin
        if (rst | system_stop) begin
            reg_access_q <= 1'b0;
            reg_write_q  <= 1'b0;
            reg_low_q    <= 1'b0;
            reg_high_q   <= 1'b0;
        end else begin
            reg_access_q <= slave_ok & (host_read | host_write); // R08
            reg_write_q  <= slave_ok & host_write & ~host_read;  // R02
            if (mode01) begin
                reg_low_q  <= ~low_byte_select_line_i; // R06
                reg_high_q <= ~hbs_eff; // R07
            end else begin
                reg_low_q  <= ~low_byte_select_line_i; // R06
                reg_high_q <= ~hbs_eff; // R07
            end
        end
    end
endmodule

/* tb/host_bus_pin_control_asserts.sv */
// Purpose: pin-role checks on the host bus control block
// Assumes: outputs registered one cycle behind their cause
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module host_bus_pin_control_asserts (
    input wire       sys_clk, rst, system_stop, bus_grant_input,
    input wire [1:0] cpu_mode,
    input wire       dma_req, dma_write, dma_done_q, reg_busy, cs_n,
    input wire       rd_i, reg_access_q, reg_write_q, master_q,
    input wire       rd_o_q, rd_oe_q, wr_o_q, wr_oe_q, lbs_oe_q,
    input wire       hbs_oe_q, wait_o_q, wait_oe_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire slave = !master_q && !system_stop;
    a_stop_pins_in:
    assert property (system_stop |=> !rd_oe_q && !wr_oe_q && !lbs_oe_q
        && !hbs_oe_q && wait_o_q && wait_oe_q) else $error("stop pins");
    a_slave_no_drive:
    assert property (slave && !$past(master_q) |-> !lbs_oe_q && !hbs_oe_q)
        else $error("slave drives select");
    a_cs_starts_read:
    assert property (slave && !cs_n && !rd_i && !cpu_mode[1]
        |=> reg_access_q && !reg_write_q) else $error("no slave read");
    a_read_unused:
    assert property (cpu_mode[1] |-> !rd_oe_q) else $error("read driven");
    a_grant_first:
    assert property ($rose(master_q) |-> $past(bus_grant_input))
        else $error("master without grant");
    a_done_min_len:
    assert property ($rose(dma_req) && master_q
        |-> !dma_done_q[*5] ##[1:40] dma_done_q)
        else $error("done timing");
    a_dir_master:
    assert property ($rose(dma_req) && master_q && cpu_mode[1]
        |-> ##[1:5] wr_oe_q && wr_o_q == !dma_write)
        else $error("direction wrong");
    a_read_strobe:
    assert property ($rose(dma_req) && master_q && !cpu_mode[1]
        && !dma_write |-> ##[2:4] !rd_o_q) else $error("no read strobe");
    a_slave_stretch:
    assert property (slave && !cs_n && !rd_i && !cpu_mode[1] && reg_busy
        |-> ##[1:2] wait_o_q) else $error("no stretch");
    cover property ($rose(dma_done_q));
    cover property (reg_access_q && reg_write_q);
    cover property (system_stop && wait_o_q);
endmodule
bind host_bus_pin_control host_bus_pin_control_asserts u_chk (.*);

/* tb/host_bus_model.sv */
// Purpose: host bus and slow memory seen from the pins
// Assumes: released strobes pulled high by the board
// Notes:   host levels come from the bench
`timescale 1ns/1ps
module host_bus_model (
    input  wire rd_o, rd_oe, wr_o, wr_oe, lbs_o, lbs_oe, hbs_o, hbs_oe,
    input  wire wait_o, wait_oe, h_rd, h_wr, h_lbs, slow,
    output wire rd, wr, lbs, hbs, wt
);
    assign rd  = rd_oe ? rd_o : h_rd;
    assign wr  = wr_oe ? wr_o : h_wr;
    assign lbs = lbs_oe ? lbs_o : h_lbs;
    assign hbs = hbs_oe ? hbs_o : 1'b1;
    // Memory holds wait high to stretch master cycles
    assign wt  = wait_oe ? wait_o : slow;
endmodule

/* tb/host_bus_pin_control_test.sv */
// Purpose: self-checking bench for host bus pin control
// Assumes: host_bus_model resolves the shared pins
// Notes:   slave cases as rows, master cases by hand
`timescale 1ns/1ps
module host_bus_pin_control_test;
    logic sys_clk = 0, rst = 1, stop = 0, grant = 0, req = 0, dwr = 0;
    logic cs_n = 1, busy = 0, h_rd = 1, h_wr = 1, h_lbs = 1, slow = 0;
    logic [1:0] mode = 2'h0;
    wire rd_o, rd_oe, wr_o, wr_oe, lbs_o, lbs_oe, hbs_o, hbs_oe;
    wire rd, wr, lbs, hbs, wt, done, acc, wrq, master, wait_o, wait_oe;
    int err_count = 0, tests_run = 0, n0, n1;
    // Mode, rd, wr, low select, cs_n, access, write
    logic [7:0] rows [6] = '{8'h12, 8'h63, 8'hB2, 8'hE3, 8'h98, 8'h14};
    host_bus_pin_control uut (
        .sys_clk(sys_clk), .rst(rst), .cpu_mode(mode), .system_stop(stop),
        .bus_grant_input(grant), .dma_req(req), .dma_write(dwr),
        .dma_addr0(1'b0), .dma_high_byte(1'b1), .dma_low_byte(1'b1),
        .dma_done_q(done), .reg_busy(busy), .reg_access_q(acc),
        .reg_write_q(wrq), .reg_low_q(), .reg_high_q(), .rd_i(rd),
        .rd_o_q(rd_o), .rd_oe_q(rd_oe), .wr_i(wr), .wr_o_q(wr_o),
        .wr_oe_q(wr_oe), .low_byte_select_line_i(lbs), .lbs_o_q(lbs_o),
        .lbs_oe_q(lbs_oe), .high_byte_select_line_i(hbs), .hbs_o_q(hbs_o),
        .hbs_oe_q(hbs_oe), .cs_n(cs_n), .wait_i(wt), .wait_o_q(wait_o),
        .wait_oe_q(wait_oe), .master_q(master));
    host_bus_model host (
        .rd_o(rd_o), .rd_oe(rd_oe), .wr_o(wr_o), .wr_oe(wr_oe),
        .lbs_o(lbs_o), .lbs_oe(lbs_oe), .hbs_o(hbs_o), .hbs_oe(hbs_oe),
        .wait_o(wait_o), .wait_oe(wait_oe), .h_rd(h_rd), .h_wr(h_wr),
        .h_lbs(h_lbs), .slow(slow), .rd(rd), .wr(wr), .lbs(lbs),
        .hbs(hbs), .wt(wt));
    initial forever #25 sys_clk = ~sys_clk;
    task tick(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask
    task chk(input string s, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s exp %b got %b", s, e, g);
        end
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Mode only changes under reset, it is a strap
    task do_reset(input logic [1:0] m, input int k);
        rst = 1;
        mode = m;
        tick(k);
        rst = 0;
        tick(7);
    endtask
    task xfer(input logic w, input int sl, output int n);
        n = 0;
        dwr = w;
        req = 1;
        slow = sl > 0;
        while (done !== 1'b1 && n < 40) begin
            tick(1);
            n++;
            if (n == sl) slow = 0;
        end
        req = 0;
    endtask
    initial begin
        tick(2);
        chk("rst wait", 1'b1, wait_o & wait_oe);
        foreach (rows[i]) begin
            do_reset(rows[i][7:6], 6);
            {h_rd, h_wr, h_lbs, cs_n} = rows[i][5:2];
            tick(2);
            chk("access", rows[i][1], acc);
            if (rows[i][1]) chk("write", rows[i][0], wrq);
            {h_rd, h_wr, h_lbs, cs_n} = 4'hF;
        end
        do_reset(2'h0, 6);
        {h_rd, cs_n, busy} = 3'b001;
        tick(3);
        chk("stretch", 1'b1, wait_o);
        stop = 1;
        tick(2);
        chk("stop access", 1'b0, acc);
        chk("stop wait", 1'b1, wait_o & wait_oe);
        chk("stop oe", 1'b0, rd_oe | wr_oe | lbs_oe | hbs_oe);
        {stop, busy, h_rd, cs_n} = 4'b0011;
        for (int m = 0; m < 4; m += 2) begin
            do_reset(m[1:0], 6);
            chk("no grant", 1'b0, master);
            grant = 1;
            cs_n = 0;
            for (n0 = 0; n0 < 20 && master !== 1'b1; n0++) tick(1);
            xfer(1'b0, 0, n0);
            tick(1);
            xfer(1'b1, 4, n1);
            chk("fast", 1'b1, n0 inside {5, 6});
            chk("stretched", 1'b1, n1 > n0);
            chk("cs in master", 1'b0, acc);
            {grant, cs_n} = 2'b01;
        end
        end_of_test;
    end
    // Whole run is under two hundred cycles
    initial begin
        #100000;
        err_count++;
        end_of_test;
    end
endmodule
